// File: common/lgp_defs.svh
`ifndef LGP_DEFS_SVH
`define LGP_DEFS_SVH

// chain and field geometry
`define LGP_CHANNELS      16
`define LGP_PWM_BITS      12
`define LGP_TRIM_BITS     7
`define LGP_GRAY_LEN      192
`define LGP_TRIM_LEN      112
`define LGP_STATUS_LEN    17
`define LGP_GRAY_KEEP     175
// open-led sample point after blanking falls
`define LGP_SAMPLE_EDGE   12'h021
`define LGP_CNT_ZERO      12'h000
`define LGP_CNT_ONE       12'h001

`endif

// File: common/lgp_pkg.sv
package lgp_pkg;
	typedef logic [11:0]  lgp_count_type;
	typedef logic [191:0] lgp_gray_type;
	typedef logic [111:0] lgp_trim_type;
	typedef logic [16:0]  lgp_status_type;
	typedef logic [15:0]  lgp_chan_type;
endpackage : lgp_pkg

// File: logic/lgp_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for a bundle of pin levels
module lgp_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] dout_q;
	logic [W-1:0] dout_d;

	// next values
	always_comb begin
		meta_d = din;
		dout_d = meta_q;
	end

	// registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= '0;
			dout_q <= '0;
		end else begin
			meta_q <= meta_d;
			dout_q <= dout_d;
		end
	end

	assign dout = dout_q;
endmodule : lgp_sync

// File: logic/lgp_core.sv
`timescale 1ns/1ps
`include "lgp_defs.svh"
// Functional notes
// - 12-bit counter counts gray clock rises
// - blanking high holds counter at zero
// - counter increments each edge after blanking
// - nonzero channels turn on first edge
// - channel off when count exceeds value
// - all sinks off while blanking high
// - on time equals value times period
// - latch strobe turns off at once channels whose new value is below the count
// - 192-bit gray chain, msb first
// - gray strobe rise copies chain to latch
// - 112-bit trim chain, msb first
// - trim strobe rise copies chain to latch
// - first edge after strobe loads status
// - chain outgoing bit drives serial out
// - open flags sampled at 33rd edge
// - only lit channels checked; 1 means open
// - thermal cutoff input 1 forces drivers off
// - status holds saved flags plus overheat
// - after overheat, restart at next period
module lgp_core
(
	input  wire logic                  clk,
	input  wire logic                  arst_n,
	input  wire logic                  gray_shift_clock,
	input  wire logic                  gray_serial_in,
	input  wire logic                  gray_latch_strobe,
	input  wire logic                  trim_shift_clock,
	input  wire logic                  trim_serial_in,
	input  wire logic                  trim_latch_strobe,
	input  wire logic                  blank,
	input  wire logic                  thermal_cutoff,
	input  wire lgp_pkg::lgp_chan_type led_open_sense,
	output logic                       gray_serial_out,
	output lgp_pkg::lgp_chan_type      sink_channel,
	output lgp_pkg::lgp_trim_type      current_trim,
	output logic                       overheat_flag
);
	import lgp_pkg::*;

	// pin order: gclk, gin, glat, tclk, tin, tlat, blank, therm
	logic [7:0]     pin_s;
	lgp_chan_type   sense_s;
	logic           gclk_prev_q, tclk_prev_q, glat_prev_q, tlat_prev_q;
	logic           gclk_rise, tclk_rise, glat_rise, glat_fall, tlat_rise;
	logic           blank_s, therm_s;

	lgp_sync #(.W(8)) u_pin_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.din    ({gray_shift_clock, gray_serial_in, gray_latch_strobe, trim_shift_clock,
		          trim_serial_in, trim_latch_strobe, blank, thermal_cutoff}),
		.dout   (pin_s)
	);
	lgp_sync #(.W(16)) u_sense_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.din    (led_open_sense),
		.dout   (sense_s)
	);

	assign blank_s   = pin_s[1];
	assign therm_s   = pin_s[0];
	assign gclk_rise = pin_s[7] & ~gclk_prev_q;
	assign tclk_rise = pin_s[4] & ~tclk_prev_q;
	assign glat_rise = pin_s[5] & ~glat_prev_q;
	assign glat_fall = ~pin_s[5] & glat_prev_q;
	assign tlat_rise = pin_s[2] & ~tlat_prev_q;

	// channel field of the brightness latch, channel 15 at msb end
	function automatic lgp_count_type chan_level(input lgp_gray_type v, input int ch);
		chan_level = v[ch*`LGP_PWM_BITS +: `LGP_PWM_BITS];
	endfunction : chan_level

	lgp_gray_type   gray_sr_q, gray_sr_d, gray_lat_q, gray_lat_d;
	lgp_trim_type   trim_sr_q, trim_sr_d, trim_lat_q, trim_lat_d;
	lgp_count_type  cnt_q, cnt_d;
	lgp_chan_type   sink_q, sink_d, open_q, open_d;
	logic           status_pend_q, status_pend_d;
	logic           heat_q, heat_d, hold_off_q, hold_off_d;
	logic           gclk_prev_d, tclk_prev_d, glat_prev_d, tlat_prev_d;
	logic           sout_q, sout_d;

	// edge detectors
	always_comb begin
		gclk_prev_d = pin_s[7];
		tclk_prev_d = pin_s[4];
		glat_prev_d = pin_s[5];
		tlat_prev_d = pin_s[2];
	end

	// shift chains and latches
	always_comb begin
		gray_sr_d     = gray_sr_q;
		gray_lat_d    = gray_lat_q;
		trim_sr_d     = trim_sr_q;
		trim_lat_d    = trim_lat_q;
		status_pend_d = status_pend_q;
		heat_d        = heat_q;
		if (gclk_rise) begin
			gray_sr_d = {gray_sr_q[`LGP_GRAY_LEN-2:0], pin_s[6]};
			if (status_pend_q) begin
				heat_d = therm_s;
				gray_sr_d[`LGP_GRAY_LEN-1 -: `LGP_STATUS_LEN] = {therm_s, open_q};
				gray_sr_d[`LGP_GRAY_KEEP-1:0] = gray_sr_q[`LGP_GRAY_KEEP-1:0];
				status_pend_d = 1'b0;
			end
		end
		if (glat_fall) // arming wins over a load in the same cycle
			status_pend_d = 1'b1;
		if (glat_rise)
			gray_lat_d = gray_sr_q;
		if (tclk_rise)
			trim_sr_d = {trim_sr_q[`LGP_TRIM_LEN-2:0], pin_s[3]};
		if (tlat_rise)
			trim_lat_d = trim_sr_q;
	end

	// pwm counter, sinks, open-led capture, overheat hold-off
	always_comb begin
		cnt_d      = cnt_q;
		sink_d     = sink_q;
		open_d     = open_q;
		hold_off_d = hold_off_q | therm_s;
		if (blank_s) begin
			cnt_d  = `LGP_CNT_ZERO;
			sink_d = '0;
			if (!therm_s)
				hold_off_d = 1'b0;
		end else if (gclk_rise) begin
			cnt_d = cnt_q + `LGP_CNT_ONE;
			for (int ch = 0; ch < `LGP_CHANNELS; ch++) begin
				// on while next count <= value
				sink_d[ch] = (cnt_d != `LGP_CNT_ZERO) && (cnt_d <= chan_level(gray_lat_q, ch));
			end
			if (cnt_d == `LGP_SAMPLE_EDGE)
				open_d = sink_q & sense_s;
		end else begin
			for (int ch = 0; ch < `LGP_CHANNELS; ch++) begin
				// latched value applies mid-period
				sink_d[ch] = sink_q[ch] && (cnt_q <= chan_level(gray_lat_d, ch));
			end
		end
		if (therm_s || hold_off_d)
			sink_d = '0;
	end

	assign sout_d = gray_sr_d[`LGP_GRAY_LEN-1];

	// registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			gclk_prev_q   <= 1'b0;
			tclk_prev_q   <= 1'b0;
			glat_prev_q   <= 1'b0;
			tlat_prev_q   <= 1'b0;
			gray_sr_q     <= '0;
			gray_lat_q    <= '0;
			trim_sr_q     <= '0;
			trim_lat_q    <= '0;
			status_pend_q <= 1'b0;
			heat_q        <= 1'b0;
			cnt_q         <= `LGP_CNT_ZERO;
			sink_q        <= '0;
			open_q        <= '0;
			hold_off_q    <= 1'b0;
			sout_q        <= 1'b0;
		end else begin
			gclk_prev_q   <= gclk_prev_d;
			tclk_prev_q   <= tclk_prev_d;
			glat_prev_q   <= glat_prev_d;
			tlat_prev_q   <= tlat_prev_d;
			gray_sr_q     <= gray_sr_d;
			gray_lat_q    <= gray_lat_d;
			trim_sr_q     <= trim_sr_d;
			trim_lat_q    <= trim_lat_d;
			status_pend_q <= status_pend_d;
			heat_q        <= heat_d;
			cnt_q         <= cnt_d;
			sink_q        <= sink_d;
			open_q        <= open_d;
			hold_off_q    <= hold_off_d;
			sout_q        <= sout_d;
		end
	end

	assign gray_serial_out = sout_q;
	assign sink_channel    = sink_q;
	assign current_trim    = trim_lat_q;
	assign overheat_flag   = heat_q;

	// channels whose latched value is nonzero
	function automatic lgp_chan_type nonzero_mask(input lgp_gray_type v);
		nonzero_mask = '0;
		for (int ch = 0; ch < `LGP_CHANNELS; ch++) begin
			nonzero_mask[ch] = (chan_level(v, ch) != `LGP_CNT_ZERO);
		end
	endfunction : nonzero_mask

	// channels whose latched value lies below a count
	function automatic lgp_chan_type over_mask(input lgp_gray_type v, input lgp_count_type c);
		over_mask = '0;
		for (int ch = 0; ch < `LGP_CHANNELS; ch++) begin
			over_mask[ch] = (c > chan_level(v, ch));
		end
	endfunction : over_mask

	// checks
	property p_blank_zero;
		@(posedge clk) disable iff (!arst_n) blank_s |=> (cnt_q == `LGP_CNT_ZERO);
	endproperty
	a_blank_zero: assert property (p_blank_zero) else $error("counter not zero while blanked");

	property p_blank_off;
		@(posedge clk) disable iff (!arst_n) blank_s |=> (sink_q == '0);
	endproperty
	a_blank_off: assert property (p_blank_off) else $error("sink on while blanked");

	property p_count_step;
		@(posedge clk) disable iff (!arst_n) (!blank_s && gclk_rise) |=> (cnt_q == $past(cnt_q) + `LGP_CNT_ONE);
	endproperty
	a_count_step: assert property (p_count_step) else $error("counter did not step");

	property p_count_hold;
		@(posedge clk) disable iff (!arst_n) (!blank_s && !gclk_rise) |=> $stable(cnt_q);
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("counter moved without edge");

	property p_gray_latch;
		@(posedge clk) disable iff (!arst_n) glat_rise |=> (gray_lat_q == $past(gray_sr_q));
	endproperty
	a_gray_latch: assert property (p_gray_latch) else $error("brightness latch not loaded");

	property p_trim_latch;
		@(posedge clk) disable iff (!arst_n) tlat_rise |=> (trim_lat_q == $past(trim_sr_q));
	endproperty
	a_trim_latch: assert property (p_trim_latch) else $error("trim latch not loaded");

	property p_status_load;
		@(posedge clk) disable iff (!arst_n) (gclk_rise && status_pend_q)
			|=> (gray_sr_q[`LGP_GRAY_LEN-1:`LGP_GRAY_KEEP] == {$past(therm_s), $past(open_q)});
	endproperty
	a_status_load: assert property (p_status_load) else $error("status not loaded");

	property p_serial_out;
		@(posedge clk) disable iff (!arst_n) (gclk_rise && !status_pend_q)
			|=> (gray_serial_out == $past(gray_sr_q[`LGP_GRAY_LEN-2]));
	endproperty
	a_serial_out: assert property (p_serial_out) else $error("serial out mismatch");

	property p_heat_off;
		@(posedge clk) disable iff (!arst_n) therm_s |=> (sink_q == '0);
	endproperty
	a_heat_off: assert property (p_heat_off) else $error("sink on during overheat");

	property p_open_only_lit;
		@(posedge clk) disable iff (!arst_n) $changed(open_q) |-> ((open_q & ~$past(sink_q)) == '0);
	endproperty
	a_open_only_lit: assert property (p_open_only_lit) else $error("flag for unlit channel");

	property p_gray_shift;
		@(posedge clk) disable iff (!arst_n) (gclk_rise && !status_pend_q)
			|=> (gray_sr_q == {$past(gray_sr_q[`LGP_GRAY_LEN-2:0]), $past(pin_s[6])});
	endproperty
	a_gray_shift: assert property (p_gray_shift) else $error("brightness chain did not shift");

	property p_first_on;
		@(posedge clk) disable iff (!arst_n)
			(!blank_s && gclk_rise && cnt_q == `LGP_CNT_ZERO && !therm_s && !hold_off_q)
			|=> (sink_q == nonzero_mask($past(gray_lat_q)));
	endproperty
	a_first_on: assert property (p_first_on) else $error("nonzero channel not on at first edge");

	property p_sink_off;
		@(posedge clk) disable iff (!arst_n) (!blank_s && gclk_rise)
			|=> ((sink_q & over_mask($past(gray_lat_q), $past(cnt_q) + `LGP_CNT_ONE)) == '0);
	endproperty
	a_sink_off: assert property (p_sink_off) else $error("channel on past its value");

	property p_mid_latch;
		@(posedge clk) disable iff (!arst_n) (glat_rise && !gclk_rise && !blank_s)
			|=> ((sink_q & over_mask(gray_lat_q, cnt_q)) == '0);
	endproperty
	a_mid_latch: assert property (p_mid_latch) else $error("new value not applied at once");

	property p_open_hold;
		@(posedge clk) disable iff (!arst_n) $changed(open_q) |-> (cnt_q == `LGP_SAMPLE_EDGE && $changed(cnt_q));
	endproperty
	a_open_hold: assert property (p_open_hold) else $error("open flags moved off the sample edge");

	property p_heat_hold;
		@(posedge clk) disable iff (!arst_n) $changed(heat_q) |-> ($past(gclk_rise) && $past(status_pend_q));
	endproperty
	a_heat_hold: assert property (p_heat_hold) else $error("overheat flag moved off status load");

	property p_hold_off;
		@(posedge clk) disable iff (!arst_n) hold_off_q |=> (sink_q == '0);
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("sink on before restart");

	c_count_run:  cover property (@(posedge clk) disable iff (!arst_n) cnt_q == `LGP_SAMPLE_EDGE);
	c_status:     cover property (@(posedge clk) disable iff (!arst_n) gclk_rise && status_pend_q);
	c_sink_on:    cover property (@(posedge clk) disable iff (!arst_n) sink_q != '0);
	c_mid_latch:  cover property (@(posedge clk) disable iff (!arst_n) glat_rise && !blank_s);
endmodule : lgp_core

// File: verif/lgp_host_model.sv
`timescale 1ns/1ps
// host side: drives both serial ports and blanking at clk falling edges
module lgp_host_model (
	input  wire logic clk,
	input  wire logic gray_serial_out,
	output logic      gray_shift_clock,
	output logic      gray_serial_in,
	output logic      gray_latch_strobe,
	output logic      trim_shift_clock,
	output logic      trim_serial_in,
	output logic      trim_latch_strobe,
	output logic      blank
);
	import lgp_pkg::*;

	// power-on: clocks still, outputs blanked until both latches are loaded
	initial begin
		gray_shift_clock  = 1'b0;
		gray_serial_in    = 1'b0;
		gray_latch_strobe = 1'b0;
		trim_shift_clock  = 1'b0;
		trim_serial_in    = 1'b0;
		trim_latch_strobe = 1'b0;
		blank             = 1'b1;
	end

	// half of a link clock period, counted in clk falling edges
	task automatic half();
		repeat (8) @(negedge clk);
	endtask : half

	// one gray clock pulse; so is the outgoing bit just before the rise
	task automatic gray_bit(input logic d, output logic so);
		gray_serial_in = d;
		half();
		so = gray_serial_out;
		gray_shift_clock = 1'b1;
		half();
		gray_shift_clock = 1'b0;
	endtask : gray_bit

	// full brightness frame, msb first, then latch strobe pulse
	task automatic gray_load(input lgp_gray_type v);
		logic so;
		for (int i = 191; i >= 0; i--) gray_bit(v[i], so);
		gray_serial_in = ~v[0]; // data line not meaningful after the frame
		gray_latch_strobe = 1'b1;
		half();
		gray_latch_strobe = 1'b0;
		half();
	endtask : gray_load

	// full trim frame, msb first, then latch strobe pulse
	task automatic trim_load(input lgp_trim_type v);
		for (int i = 111; i >= 0; i--) begin
			trim_serial_in = v[i];
			half();
			trim_shift_clock = 1'b1;
			half();
			trim_shift_clock = 1'b0;
		end
		trim_serial_in = ~v[0]; // data line not meaningful after the frame
		trim_latch_strobe = 1'b1;
		half();
		trim_latch_strobe = 1'b0;
		half();
	endtask : trim_load

	// blanking level change, then settle
	task automatic set_blank(input logic b);
		blank = b;
		half();
	endtask : set_blank
endmodule : lgp_host_model

// File: verif/lgp_core_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fails++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end
module lgp_core_tb_top;
	import lgp_pkg::*;
	logic         clk = 1'b0, arst_n = 1'b0, thermal_cutoff = 1'b0;
	lgp_chan_type led_open_sense = 16'h0007;
	logic         gsc, gsi, gls, tsc, tsi, tls, blank, gso, ovh, so;
	lgp_chan_type sink, ex;
	lgp_trim_type trim;
	lgp_gray_type gv;
	logic [16:0]  st;
	int           fails = 0, n_tests = 0;

	// 125 MHz system clock
	always #4 clk = ~clk;

	lgp_core u_lgp_core (.clk(clk), .arst_n(arst_n), .gray_shift_clock(gsc), .gray_serial_in(gsi),
		.gray_latch_strobe(gls), .trim_shift_clock(tsc), .trim_serial_in(tsi), .trim_latch_strobe(tls),
		.blank(blank), .thermal_cutoff(thermal_cutoff), .led_open_sense(led_open_sense),
		.gray_serial_out(gso), .sink_channel(sink), .current_trim(trim), .overheat_flag(ovh));
	lgp_host_model u_lgp_host_model (.clk(clk), .gray_serial_out(gso), .gray_shift_clock(gsc),
		.gray_serial_in(gsi), .gray_latch_strobe(gls), .trim_shift_clock(tsc), .trim_serial_in(tsi),
		.trim_latch_strobe(tls), .blank(blank));

	// counts and verdict, then end of run
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : finish_test

	// main sequence
	initial begin
		repeat (2) @(negedge clk);
		arst_n = 1'b1;
		repeat (4) @(negedge clk);
		u_lgp_host_model.trim_load({7'h7F, 98'h0, 7'h01});
		`CHK("trim", {7'h7F, 98'h0, 7'h01}, trim)
		gv = '0;
		gv[11:0] = 12'h001;
		gv[35:24] = 12'h021;
		gv[47:36] = 12'hFFF;
		u_lgp_host_model.gray_load(gv);
		`CHK("sink blanked", 16'h0000, sink)
		u_lgp_host_model.set_blank(1'b0);
		for (int n = 1; n <= 40; n++) begin
			u_lgp_host_model.gray_bit(1'b0, so);
			for (int c = 0; c < 16; c++) ex[c] = (gv[12*c+:12] != 12'h000) && (n <= gv[12*c+:12]);
			`CHK("sink", ex, sink)
		end
		u_lgp_host_model.set_blank(1'b1);
		u_lgp_host_model.gray_bit(1'b0, so);
		`CHK("sink blank", 16'h0000, sink)
		thermal_cutoff = 1'b1;
		u_lgp_host_model.gray_load(gv);
		u_lgp_host_model.gray_bit(1'b0, so);
		for (int i = 16; i >= 0; i--) begin
			u_lgp_host_model.gray_bit(1'b0, so);
			st[i] = so;
		end
		`CHK("status", {1'b1, 16'h0004}, st)
		`CHK("overheat", 1'b1, ovh)
		u_lgp_host_model.set_blank(1'b0);
		u_lgp_host_model.gray_bit(1'b0, so);
		`CHK("sink hot", 16'h0000, sink)
		thermal_cutoff = 1'b0;
		u_lgp_host_model.gray_bit(1'b0, so);
		`CHK("sink cooled", 16'h0000, sink)
		u_lgp_host_model.set_blank(1'b1);
		u_lgp_host_model.set_blank(1'b0);
		u_lgp_host_model.gray_bit(1'b0, so);
		`CHK("sink restart", 16'h000D, sink)
		gv[47:36] = 12'h000;
		u_lgp_host_model.gray_load(gv);
		`CHK("sink mid latch", 16'h0000, sink)
		finish_test();
	end

	// watchdog well beyond the expected run length
	initial begin
		#500us;
		fails++;
		finish_test();
	end
endmodule : lgp_core_tb_top
